/* File: src/tpg_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: Pin three change raises event when enabled
// R2: Event is sticky, masked onto interrupt output
// R3: Pin three invert bit flips its polarity
// R4: Pin three driven only while enable set
// R5: Pin three data reads input, writes drive
// R6: Pin two invert bit flips its polarity
// R7: Pin two driven only while enable set
// R8: Pin two data reads input, writes drive
// R9: Reserved control bits read back zero
// R10: Control register at FCh, reset 00001010h (code ANDs it with TPG_WMASK, so every stored bit resets to zero)
// R11: Pin two change raises event when enabled
// R12: Inversion applies to sense, drive, change detect
module tpg_ctrl
   import tpg_pkg::*;
(
   // Clock and reset.
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   // Configuration space access.
   input  wire tpg_cfg_req_s         cfg_req,
   output logic [31:0]               cfg_rdata_q,
   output logic                      cfg_rvalid_q,
   // Pins: index 0 is pin two, index 1 is pin three.
   input  wire logic [TPG_NPINS-1:0] pin_in,
   output logic [TPG_NPINS-1:0]      pin_out_q,
   output logic [TPG_NPINS-1:0]      pin_oe_q,
   // Host interrupt event and mask hookup.
   input  wire logic                 event_mask,
   input  wire logic                 event_clear,
   output logic                      general_pin_event_q,
   output logic                      general_pin_irq_q
);

   logic [31:0]               ctrl_q;
   logic [31:0]               ctrl_d;
   logic [TPG_NPINS-1:0]      sync1_q;
   logic [TPG_NPINS-1:0]      sync2_q;
   logic [TPG_NPINS-1:0]      prev_q;
   logic [TPG_ARM_CYCLES-1:0] arm_q;

   wire logic                 hit;
   wire logic                 wr_hit;
   wire logic                 rd_hit;
   wire logic [31:0]          be_mask;
   wire logic [31:0]          wr_mask;
   wire logic [31:0]          rd_word;
   wire logic [31:0]          sense_word;
   wire logic                 armed;
   wire logic                 any_change;
   wire logic                 event_d;
   wire logic [TPG_NPINS-1:0] sensed;
   wire logic [TPG_NPINS-1:0] change;
   wire logic [TPG_NPINS-1:0] out_d;
   wire logic [TPG_NPINS-1:0] oe_d;

   assign hit     = (cfg_req.addr == TPG_CTRL_OFS); // R10
   assign wr_hit  = cfg_req.wr & hit;
   assign rd_hit  = cfg_req.rd & hit;
   assign be_mask = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}},
                     {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
   assign wr_mask = be_mask & TPG_WMASK; // R9
   assign ctrl_d  = wr_hit ? ((ctrl_q & ~wr_mask) |
                              (cfg_req.wdata & wr_mask)) : ctrl_q; // R5 R8
   // The synchroniser starts at zero, so a pin held high looks like a
   // change just after reset; the arming chain hides that first edge.
   assign armed   = arm_q[TPG_ARM_CYCLES-1];

   genvar p;
   generate
      for (p = 0; p < TPG_NPINS; p++) begin : g_pin
         localparam int B = TPG_PIN_BASE + p * TPG_PIN_STRIDE;
         // Inversion sits on both directions of the pin.
         assign sensed[p] = sync2_q[p] ^ ctrl_q[B+TPG_INV_POS]; // R3 R6 R12
         assign out_d[p]  = ctrl_d[B+TPG_DATA_POS] ^
                            ctrl_d[B+TPG_INV_POS]; // R3 R6 R12
         assign oe_d[p]   = ctrl_d[B+TPG_OE_POS]; // R4 R7
         assign change[p] = armed & ctrl_q[B+TPG_EVEN_POS] &
                            (sensed[p] != prev_q[p]); // R1 R11 R12
         assign sense_word[B+TPG_DATA_POS] = sensed[p]; // R5 R8
         if (TPG_DATA_POS > 0) begin : g_lo
            assign sense_word[B+TPG_DATA_POS-1:B] = '0;
         end
         assign sense_word[B+TPG_PIN_STRIDE-1:B+TPG_DATA_POS+1] = '0;
      end
   endgenerate
   assign sense_word[TPG_PIN_BASE-1:0] = '0;

   // Stored data bits hold the drive value; reads show the pin instead.
   assign rd_word    = (ctrl_q & TPG_WMASK & ~sense_mask()) | sense_word;
   assign any_change = |change;
   // A new change wins over a clear in the same cycle.
   assign event_d    = any_change |
                       (general_pin_event_q & ~event_clear); // R2

   function automatic logic [31:0] sense_mask();
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < TPG_NPINS; i++) begin
         m[TPG_PIN_BASE + i * TPG_PIN_STRIDE + TPG_DATA_POS] = 1'b1;
      end
      return m;
   endfunction : sense_mask

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= TPG_CTRL_RESET & TPG_WMASK; // R9 R10
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
         arm_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q <= sensed;
         arm_q <= {arm_q[TPG_ARM_CYCLES-2:0], 1'b1};
      end
   end

   // Read data is zero except in the cycle after a read of this offset.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_out_q <= '0;
         pin_oe_q <= '0;
         cfg_rdata_q <= '0;
         cfg_rvalid_q <= 1'b0;
         general_pin_event_q <= 1'b0;
         general_pin_irq_q <= 1'b0;
      end else begin
         pin_out_q <= out_d;
         pin_oe_q <= oe_d; // R4 R7
         cfg_rdata_q <= rd_hit ? rd_word : 32'h0000_0000;
         cfg_rvalid_q <= cfg_req.rd;
         general_pin_event_q <= event_d; // R1 R11 R2
         general_pin_irq_q <= event_d & event_mask; // R2
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_change3;
      armed && ctrl_q[31] && (sensed[1] != prev_q[1]);
   endsequence
   sequence s_change2;
      armed && ctrl_q[23] && (sensed[0] != prev_q[0]);
   endsequence

   chk_event_pin_three: assert property ( // R1
      s_change3 |=> general_pin_event_q)
      else $error("Pin three change did not raise event.");
   chk_event_pin_two: assert property ( // R11
      s_change2 |=> general_pin_event_q)
      else $error("Pin two change did not raise event.");
   chk_event_sticky_mask: assert property ( // R2
      general_pin_event_q && !event_clear && !any_change
      |=> general_pin_event_q ##0 (general_pin_irq_q == $past(event_mask)))
      else $error("Event lost or interrupt not gated by mask.");
   chk_invert_pin_three: assert property ( // R3
      wr_hit && cfg_req.be[3]
      |=> pin_out_q[1] == ($past(cfg_req.wdata[24]) ^
                           $past(cfg_req.wdata[29])))
      else $error("Pin three drive does not follow data and invert.");
   chk_enable_pin_three: assert property ( // R4
      wr_hit && cfg_req.be[3]
      |=> pin_oe_q[1] == $past(cfg_req.wdata[28]) ##1
          (pin_oe_q[1] == ctrl_q[28]))
      else $error("Pin three enable does not follow its bit.");
   chk_read_pin_three: assert property ( // R5
      rd_hit |=> cfg_rdata_q[24] == $past(sensed[1]))
      else $error("Pin three read is not the sensed input.");
   chk_invert_pin_two: assert property ( // R6
      wr_hit && cfg_req.be[2]
      |=> pin_out_q[0] == ($past(cfg_req.wdata[16]) ^
                           $past(cfg_req.wdata[21])))
      else $error("Pin two drive does not follow data and invert.");
   chk_enable_pin_two: assert property ( // R7
      wr_hit && cfg_req.be[2] |=> pin_oe_q[0] == $past(cfg_req.wdata[20]))
      else $error("Pin two enable does not follow its bit.");
   chk_read_pin_two: assert property ( // R8
      rd_hit |=> cfg_rdata_q[16] == ($past(sync2_q[0]) ^ $past(ctrl_q[21])))
      else $error("Pin two read is not the sensed input.");
   chk_reserved_zero: assert property ( // R9
      cfg_rvalid_q |-> (cfg_rdata_q & ~TPG_WMASK) == 32'h0000_0000)
      else $error("Reserved bits read nonzero.");
   chk_offset_decode: assert property ( // R10
      cfg_req.rd && !hit |=> cfg_rdata_q == 32'h0000_0000)
      else $error("Unmapped offset returned data.");

   // Flag bookkeeping around changes, clears and the quiet start.
   sequence s_flag_idle;
      !general_pin_event_q && !any_change;
   endsequence
   sequence s_flag_cleared;
      general_pin_event_q && event_clear && !any_change;
   endsequence

   chk_event_needs_change: assert property ( // R1 R11
      s_flag_idle |=> !general_pin_event_q)
      else $error("Event flag rose without an enabled change.");
   chk_event_clear_drop: assert property ( // R2
      s_flag_cleared |=> !general_pin_event_q && !general_pin_irq_q)
      else $error("Clear did not drop the event flag.");
   chk_set_beats_clear: assert property ( // R2
      any_change && event_clear |=> general_pin_event_q)
      else $error("Clear in a change cycle lost the event.");
   chk_mask_blocks_irq: assert property ( // R2
      !event_mask |=> !general_pin_irq_q)
      else $error("Interrupt raised while masked.");
   chk_quiet_after_reset: assert property ( // R1 R11
      !armed |=> !general_pin_event_q)
      else $error("Event raised before the pins settled.");

   // Drive, storage and read handshake invariants.
   chk_drive_holds: assert property ( // R4 R7
      !wr_hit |=> $stable(pin_out_q) && $stable(pin_oe_q))
      else $error("Pin drive moved without a register write.");
   chk_reserved_store: assert property ( // R9
      (ctrl_q & ~TPG_WMASK) == 32'h0000_0000)
      else $error("Reserved control bits hold a one.");
   chk_read_answer: assert property ( // R10
      cfg_req.rd |=> cfg_rvalid_q)
      else $error("Read got no valid strobe.");
   chk_read_quiet: assert property ( // R10
      !cfg_req.rd |=> !cfg_rvalid_q && cfg_rdata_q == 32'h0000_0000)
      else $error("Read data shown without a read.");

endmodule : tpg_ctrl

/* File: src/tpg_pkg.sv */
package tpg_pkg;

   localparam int          TPG_NPINS      = 2;
   localparam logic [7:0]  TPG_CTRL_OFS   = 8'hFC;
   localparam logic [31:0] TPG_CTRL_RESET = 32'h0000_1010;
   // Bits that hold state; everything else reads as zero.
   localparam logic [31:0] TPG_WMASK      = 32'hB1B1_0000;
   // Per pin fields: pin two starts at bit 16, pin three at bit 24.
   localparam int          TPG_PIN_BASE   = 16;
   localparam int          TPG_PIN_STRIDE = 8;
   localparam int          TPG_DATA_POS   = 0;
   localparam int          TPG_OE_POS     = 4;
   localparam int          TPG_INV_POS    = 5;
   localparam int          TPG_EVEN_POS   = 7;
   // Cycles after reset before level changes may raise events.
   localparam int          TPG_ARM_CYCLES = 3;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } tpg_cfg_req_s;

endpackage : tpg_pkg

/* File: verif/tpg_pin_model.sv */
`timescale 1ns/1ps
module tpg_pin_model
   import tpg_pkg::*;
(
   // Device side.
   input  wire logic [TPG_NPINS-1:0] pin_out_q,
   input  wire logic [TPG_NPINS-1:0] pin_oe_q,
   // Board side.
   input  wire logic [TPG_NPINS-1:0] board_val,
   output logic [TPG_NPINS-1:0]      pin_in
);
   // The wire follows the device while it drives, the board otherwise.
   assign pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & board_val);
endmodule : tpg_pin_model

/* File: verif/tpg_ctrl_tb.sv */
`timescale 1ns/1ps
module tpg_ctrl_tb;
   import tpg_pkg::*;
   logic         sys_clk, rst, event_mask, event_clear, cfg_rvalid_q, ev, irq;
   tpg_cfg_req_s cfg_req;
   logic [31:0]  cfg_rdata_q, rd_val, w, ctl;
   logic [7:0]   a;
   logic [1:0]   pin_in, pin_out_q, pin_oe_q, board_val;
   int           err_total, n_tests, seed;

   tpg_ctrl tpg_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .cfg_req(cfg_req),
      .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
      .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
      .event_mask(event_mask), .event_clear(event_clear),
      .general_pin_event_q(ev), .general_pin_irq_q(irq));
   tpg_pin_model tpg_pin_model_inst (.pin_out_q(pin_out_q),
      .pin_oe_q(pin_oe_q), .board_val(board_val), .pin_in(pin_in));

   function automatic logic [1:0] drv(input logic [31:0] c);
      drv = {c[24] ^ c[29], c[16] ^ c[21]};
   endfunction : drv

   function automatic logic [31:0] exp_rd(input logic [31:0] c,
                                          input logic [1:0] b);
      logic [1:0] oe;
      logic [1:0] lvl;
      oe = {c[28], c[20]};
      lvl = (oe & drv(c)) | (~oe & b);
      exp_rd = c & 32'hB0B0_0000;
      exp_rd[24] = lvl[1] ^ c[29];
      exp_rd[16] = lvl[0] ^ c[21];
   endfunction : exp_rd

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic cfg_op(input logic wr, input logic [7:0] ad,
                         input logic [31:0] d);
      @(posedge sys_clk);
      cfg_req <= '{wr: wr, rd: !wr, addr: ad, be: 4'hC, wdata: d};
      @(posedge sys_clk);
      cfg_req <= '0;
      #1 rd_val = cfg_rdata_q;
      if (!wr) chk({31'h0, cfg_rvalid_q}, 32'h1);
   endtask : cfg_op

   task automatic pulse_clear;
      @(posedge sys_clk) event_clear <= 1'b1;
      @(posedge sys_clk) event_clear <= 1'b0;
      #1;
   endtask : pulse_clear

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      report_and_stop();
   end

   initial begin
      seed = 32'hc89e;
      {rst, cfg_req, event_mask, event_clear, board_val} = '0;
      rst = 1'b1;
      board_val = 2'b10;
      {err_total, n_tests} = '0;
      ctl = '0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      cfg_op(1'b0, TPG_CTRL_OFS, 32'h0);
      chk(rd_val, exp_rd(32'h0, board_val));
      $display("reset test done");
      for (int i = 0; i < 40; i++) begin
         w = $random(seed);
         a = (i % 5 == 0) ? 8'hF8 : TPG_CTRL_OFS;
         @(posedge sys_clk) board_val <= 2'($random(seed));
         cfg_op(1'b1, a, w);
         if (a == TPG_CTRL_OFS) ctl = w;
         chk({30'h0, pin_oe_q}, {30'h0, ctl[28], ctl[20]});
         chk({30'h0, pin_out_q}, {30'h0, drv(ctl)});
         repeat (3) @(posedge sys_clk);
         cfg_op(1'b0, a, 32'h0);
         w = (a == TPG_CTRL_OFS) ? exp_rd(ctl, board_val) : '0;
         chk(rd_val, w);
      end
      $display("register test done");
      for (int p = 0; p < 2; p++) begin
         cfg_op(1'b1, TPG_CTRL_OFS, 32'h0);
         repeat (4) @(posedge sys_clk);
         pulse_clear();
         @(posedge sys_clk) board_val[p] <= ~board_val[p];
         repeat (5) @(posedge sys_clk);
         #1 chk({31'h0, ev}, 32'h0);
         cfg_op(1'b1, TPG_CTRL_OFS, p ? 32'h8000_0000 : 32'h0080_0000);
         @(posedge sys_clk) event_mask <= 1'b1;
         @(posedge sys_clk) board_val[p] <= ~board_val[p];
         repeat (5) @(posedge sys_clk);
         #1 chk({30'h0, ev, irq}, 32'h3);
         @(posedge sys_clk) event_mask <= 1'b0;
         repeat (2) @(posedge sys_clk);
         #1 chk({30'h0, ev, irq}, 32'h2);
         pulse_clear();
         chk({31'h0, ev}, 32'h0);
         // Change and clear land in one cycle: the change must win.
         @(posedge sys_clk) board_val[p] <= ~board_val[p];
         @(posedge sys_clk);
         @(posedge sys_clk) event_clear <= 1'b1;
         @(posedge sys_clk) event_clear <= 1'b0;
         #1 chk({31'h0, ev}, 32'h1);
         pulse_clear();
         chk({31'h0, ev}, 32'h0);
      end
      $display("event test done");
      report_and_stop();
   end
endmodule : tpg_ctrl_tb
